// ### logic/sdvem_defines.vh
// Register map, field positions, reset values and CRC constants of the error monitor.
`ifndef SDVEM_DEFINES_VH
`define SDVEM_DEFINES_VH
// ==========================================================================
// Host register addresses
`define SDVEM_ADDR_ERROR_FLAGS 8'h01
`define SDVEM_ADDR_ERROR_DISABLE 8'h25
`define SDVEM_ADDR_RANGE_FIRST 8'h15
`define SDVEM_ADDR_RANGE_LAST 8'h24
// ==========================================================================
// Flag and disable bit positions
`define SDVEM_BIT_ACTIVE_END 0
`define SDVEM_BIT_ACTIVE_START 1
`define SDVEM_BIT_CHECKSUM 2
`define SDVEM_BIT_LOCK 3
`define SDVEM_BIT_AP_CRC 4
`define SDVEM_BIT_FF_CRC 5
`define SDVEM_BIT_STD 6
`define SDVEM_FLAG_WIDTH 7
// ==========================================================================
// Reset values and widths
`define SDVEM_FLAGS_RESET 7'h00
`define SDVEM_DISABLE_RESET 7'h00
`define SDVEM_RANGE_RESET 13'h0000
`define SDVEM_LINE_WIDTH 11
`define SDVEM_PIXEL_WIDTH 13
`define SDVEM_RANGE_COUNT 16
// ==========================================================================
// EDH CRC generator
`define SDVEM_CRC_POLY 16'h1021
`define SDVEM_CRC_SEED 16'h0000
`endif

// ### logic/sdvem_error_monitor.v
// Error flag, disable mask, summary pin and EDH CRC range logic of the SD video receiver.
`include "sdvem_defines.vh"
`default_nettype none

module sdvem_error_monitor (
  input wire sys_clk,
  input wire srst,
  input wire [7:0] host_addr,
  input wire host_wr,
  input wire host_rd,
  input wire [15:0] host_wdata,
  output reg [15:0] host_rdata,
  input wire smpte_mode,
  input wire locked,
  input wire manual_mode,
  input wire video_processing_bypass_n,
  input wire field_start,
  input wire std_change,
  input wire pid_std_mismatch,
  input wire anc_checksum_error,
  input wire active_start_code_error,
  input wire active_end_code_error,
  input wire fmt_525,
  input wire fmt_625,
  input wire field_id,
  input wire [10:0] line_num,
  input wire [12:0] pixel_num,
  input wire flywheel_active_line,
  input wire between_sav_eav,
  input wire word_valid,
  input wire [9:0] video_word,
  input wire edh_rx_valid,
  input wire edh_rx_ok,
  input wire [15:0] edh_rx_ap_crc,
  input wire [15:0] edh_rx_ff_crc,
  output reg data_error_n
);

  // ========================================================================
  // Helper functions
  // ========================================================================

  // Advances the EDH CRC by one 10-bit word, least significant bit first.
  function [15:0] crc_step;
    input [15:0] crc;
    input [9:0] data;
    integer k;
    reg [15:0] c;
    begin
      c = crc;
      for (k = 0; k < 10; k = k + 1) begin
        if (c[15] ^ data[k]) begin
          c = {c[14:0], 1'b0} ^ `SDVEM_CRC_POLY;
        end else begin
          c = {c[14:0], 1'b0};
        end
      end
      crc_step = c;
    end
  endfunction

  // True when a position falls within an inclusive start..end window.
  function in_window;
    input [12:0] pos;
    input [12:0] first;
    input [12:0] last;
    begin
      in_window = (pos >= first) && (pos <= last);
    end
  endfunction

  // ========================================================================
  // Pin synchronisers
  // ========================================================================

  reg manual_meta;
  reg manual_sync;
  reg bypass_n_meta;
  reg bypass_n_sync;

  // Mode and bypass pins come from outside and pass two flip-flops.
  always @(posedge sys_clk) begin
    if (srst) begin
      manual_meta <= 1'b0;
      manual_sync <= 1'b0;
      bypass_n_meta <= 1'b1;
      bypass_n_sync <= 1'b1;
    end else begin
      manual_meta <= manual_mode;
      manual_sync <= manual_meta;
      bypass_n_meta <= video_processing_bypass_n;
      bypass_n_sync <= bypass_n_meta;
    end
  end

  // ========================================================================
  // Host registers
  // ========================================================================

  reg [6:0] error_flags;
  reg [6:0] error_detect_disable;
  wire [12:0] range_lim [0:15];
  wire range_sel;
  wire [3:0] range_idx;
  wire [7:0] range_off;

  assign range_off = host_addr - `SDVEM_ADDR_RANGE_FIRST;
  assign range_sel = (host_addr >= `SDVEM_ADDR_RANGE_FIRST) &&
                     (host_addr <= `SDVEM_ADDR_RANGE_LAST);
  assign range_idx = range_off[3:0];

  // Range limits: indices 0..7 hold 11-bit lines, 8..15 hold 13-bit pixels.
  genvar gi;
  generate
    for (gi = 0; gi < `SDVEM_RANGE_COUNT; gi = gi + 1) begin : g_lim
      reg [12:0] lim;
      // Each limit has its own register, so the array has one driver per word.
      always @(posedge sys_clk) begin
        if (srst) begin
          lim <= `SDVEM_RANGE_RESET;
        end else if (host_wr && range_sel && range_idx == gi) begin
          if (gi < 8) begin
            lim <= {2'b00, host_wdata[10:0]};
          end else begin
            lim <= host_wdata[12:0];
          end
        end
      end
      // Publishes the limit to the shared lookup array.
      assign range_lim[gi] = lim;
    end
  endgenerate

  // Disable mask, written by the host.
  always @(posedge sys_clk) begin
    if (srst) begin
      error_detect_disable <= `SDVEM_DISABLE_RESET;
    end else if (host_wr && host_addr == `SDVEM_ADDR_ERROR_DISABLE) begin
      error_detect_disable <= host_wdata[6:0];
    end
  end

  // Read data is registered; unused bits and unmapped addresses read zero.
  always @(posedge sys_clk) begin
    if (srst) begin
      host_rdata <= 16'h0000;
    end else if (host_rd) begin
      if (host_addr == `SDVEM_ADDR_ERROR_FLAGS) begin
        host_rdata <= {9'h000, error_flags};
      end else if (host_addr == `SDVEM_ADDR_ERROR_DISABLE) begin
        host_rdata <= {9'h000, error_detect_disable};
      end else if (range_sel) begin
        host_rdata <= {3'b000, range_lim[range_idx]};
      end else begin
        host_rdata <= 16'h0000;
      end
    end
  end

  // ========================================================================
  // EDH calculation ranges
  // ========================================================================

  reg use_host_ranges;
  reg ap_hit;
  reg ff_hit;
  wire [3:0] fsel;
  integer j;

  assign fsel = {3'b000, field_id};

  // Host limits apply only to non-standard formats with every limit nonzero.
  always @* begin
    use_host_ranges = !(fmt_525 || fmt_625);
    for (j = 0; j < `SDVEM_RANGE_COUNT; j = j + 1) begin
      if (range_lim[j] == 13'h0000) begin
        use_host_ranges = 1'b0;
      end
    end
  end

  // Window decode; flywheel timing brackets pixels between start and end codes.
  always @* begin
    if (use_host_ranges) begin
      ap_hit = in_window({2'b00, line_num}, range_lim[fsel * 2],
                         range_lim[fsel * 2 + 4'h1]) &&
               in_window(pixel_num, range_lim[4'h8 + fsel * 2],
                         range_lim[4'h9 + fsel * 2]);
      ff_hit = in_window({2'b00, line_num}, range_lim[4'h4 + fsel * 2],
                         range_lim[4'h5 + fsel * 2]) &&
               in_window(pixel_num, range_lim[4'hc + fsel * 2],
                         range_lim[4'hd + fsel * 2]);
    end else begin
      ap_hit = flywheel_active_line && between_sav_eav;
      ff_hit = between_sav_eav;
    end
  end

  // ========================================================================
  // EDH CRC accumulation and compare
  // ========================================================================

  reg [15:0] ap_crc;
  reg [15:0] ff_crc;
  reg [15:0] ap_crc_held;
  reg [15:0] ff_crc_held;

  // Accumulate within the windows; field start banks the finished values.
  always @(posedge sys_clk) begin
    if (srst) begin
      ap_crc <= `SDVEM_CRC_SEED;
      ff_crc <= `SDVEM_CRC_SEED;
      ap_crc_held <= `SDVEM_CRC_SEED;
      ff_crc_held <= `SDVEM_CRC_SEED;
    end else if (field_start) begin
      ap_crc_held <= ap_crc;
      ff_crc_held <= ff_crc;
      ap_crc <= `SDVEM_CRC_SEED;
      ff_crc <= `SDVEM_CRC_SEED;
    end else if (word_valid) begin
      if (ap_hit) begin
        ap_crc <= crc_step(ap_crc, video_word);
      end
      if (ff_hit) begin
        ff_crc <= crc_step(ff_crc, video_word);
      end
    end
  end

  // ========================================================================
  // Error flags and summary pin
  // ========================================================================

  reg [6:0] det;
  reg [6:0] next_flags;
  wire flag_clear;
  wire edh_good;

  assign edh_good = edh_rx_valid && edh_rx_ok;
  assign flag_clear = field_start || std_change || !locked ||
                      (host_rd && host_addr == `SDVEM_ADDR_ERROR_FLAGS) ||
                      (manual_sync && !bypass_n_sync);

  // Detector events, gated by the disable mask and, all but the lock bit, by SMPTE mode.
  always @* begin
    det = 7'h00;
    det[`SDVEM_BIT_ACTIVE_END] = active_end_code_error;
    det[`SDVEM_BIT_ACTIVE_START] = active_start_code_error;
    det[`SDVEM_BIT_CHECKSUM] = anc_checksum_error;
    det[`SDVEM_BIT_AP_CRC] = edh_good && (edh_rx_ap_crc != ap_crc_held);
    det[`SDVEM_BIT_FF_CRC] = edh_good && (edh_rx_ff_crc != ff_crc_held);
    det[`SDVEM_BIT_STD] = pid_std_mismatch;
    if (!smpte_mode) begin
      det = 7'h00;
    end
    det[`SDVEM_BIT_LOCK] = !locked;
    det = det & ~error_detect_disable;
  end

  // Clear first, then set, so a coincident event survives the clear.
  always @* begin
    next_flags = error_flags;
    if (flag_clear) begin
      next_flags = error_flags & 7'h08;
    end
    next_flags[`SDVEM_BIT_LOCK] = det[`SDVEM_BIT_LOCK];
    next_flags = next_flags | det;
  end

  // Flag register and the active-low summary output.
  always @(posedge sys_clk) begin
    if (srst) begin
      error_flags <= `SDVEM_FLAGS_RESET;
      data_error_n <= 1'b1;
    end else begin
      error_flags <= next_flags;
      data_error_n <= ~|(next_flags & ~error_detect_disable);
    end
  end

endmodule
`default_nettype wire

// ### tb/sdvem_props.sv
// Checker of the summary pin and register reads of the error monitor.
`default_nettype none
module sdvem_props (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata,
  input wire logic smpte_mode,
  input wire logic locked,
  input wire logic field_start,
  input wire logic std_change,
  input wire logic pid_std_mismatch,
  input wire logic anc_checksum_error,
  input wire logic active_start_code_error,
  input wire logic active_end_code_error,
  input wire logic edh_rx_valid,
  input wire logic edh_rx_ok,
  input wire logic data_error_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] mask;
  logic [6:0] evt;
  logic rd01;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ========
  // Shadow of the disable register, kept from the observed host writes.
  always @(posedge sys_clk) begin
    if (srst) begin
      mask <= 7'h00;
    end else if (host_wr && host_addr == 8'h25) begin
      mask <= host_wdata[6:0];
    end
  end
  // Event inputs in flag bit order and the status read strobe.
  assign evt = {pid_std_mismatch, 3'h0, anc_checksum_error, active_start_code_error,
    active_end_code_error};
  assign rd01 = host_rd && host_addr == 8'h01;
  // Two cycles out of lock with no register writes.
  sequence lock_lost;
    (!locked && !host_wr) [*2];
  endsequence
  a_reset_pin_high: assert property (disable iff (1'b0) srst |=> data_error_n)
    else $error("pin low after reset");
  a_reset_reads_zero: assert property (disable iff (1'b0)
    srst ##1 (rd01 && locked) |=> host_rdata == 16'h0000) else $error("flags after reset");
  a_event_pin_low: assert property (!host_wr && smpte_mode && |(evt & ~mask)
    |=> !data_error_n) else $error("event left pin high");
  a_lock_pin_low: assert property (!host_wr && !locked && !mask[3] |=> !data_error_n)
    else $error("lock loss left pin high");
  a_fall_has_cause: assert property ($fell(data_error_n) |-> $past(!locked
    || smpte_mode && (|evt || edh_rx_valid && edh_rx_ok))) else $error("pin fell alone");
  a_clear_pin_high: assert property ((field_start || std_change) && locked
    && !(|evt) && !edh_rx_valid |=> data_error_n) else $error("flags not cleared");
  a_disable_readback: assert property (host_rd && !host_wr && host_addr == 8'h25
    |=> host_rdata == {9'h000, mask}) else $error("disable readback");
  a_unused_bits_zero: assert property (rd01 |=> host_rdata[15:7] == 9'h000)
    else $error("unused flag bits set");
  a_lock_survives_read: assert property (lock_lost ##0 (rd01 && !mask[3])
    |=> host_rdata[3]) else $error("lock flag missing");
  a_rdata_holds: assert property (!host_rd |=> $stable(host_rdata))
    else $error("read data moved");
endmodule
bind sdvem_error_monitor sdvem_props u_props (.sys_clk, .srst, .host_addr, .host_wr,
  .host_rd, .host_wdata, .host_rdata, .smpte_mode, .locked, .field_start, .std_change,
  .pid_std_mismatch, .anc_checksum_error, .active_start_code_error, .active_end_code_error,
  .edh_rx_valid, .edh_rx_ok, .data_error_n);
`default_nettype wire

// ### tb/sdvem_host.sv
// Host controller model driving the register strobe port.
`default_nettype none
module sdvem_host (
  input wire logic sys_clk,
  input wire logic [15:0] host_rdata,
  output logic [7:0] host_addr = 8'h00,
  output logic host_wr = 1'b0,
  output logic host_rd = 1'b0,
  output logic [15:0] host_wdata = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // One write strobe; data is scrambled afterwards so nothing stale looks valid.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge sys_clk);
    host_wr <= 1'b0;
    host_wdata <= ~d;
  endtask
  // One read strobe; read data is taken one cycle after the strobe edge.
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge sys_clk);
    host_rd <= 1'b0;
    @(posedge sys_clk);
    d = host_rdata;
  endtask
endmodule
`default_nettype wire

// ### tb/sdvem_error_monitor_tb.sv
// Self-checking bench of the error monitor through its host register port.
`default_nettype none
module sdvem_error_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic smpte_mode = 1'b1;
  logic locked = 1'b1;
  logic manual = 1'b0;
  logic bypass_n = 1'b1;
  logic field_start = 1'b0;
  logic std_change = 1'b0;
  logic fmt_525 = 1'b1;
  logic between_sav_eav = 1'b0;
  logic [10:0] line_num = 11'h000;
  logic [12:0] pixel_num = 13'h0000;
  logic edh_v = 1'b0;
  logic edh_ok = 1'b0;
  logic [15:0] crc_ap = 16'h0000;
  logic [15:0] crc_ff = 16'h0000;
  logic [6:0] evt = 7'h00;
  logic [6:0] evs [4] = '{7'h01, 7'h02, 7'h04, 7'h40};
  logic [7:0] host_addr;
  logic host_wr;
  logic host_rd;
  logic [15:0] host_wdata;
  logic [15:0] host_rdata;
  logic data_error_n;
  logic [15:0] d;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  sdvem_host u_host (.sys_clk, .host_rdata, .host_addr, .host_wr, .host_rd, .host_wdata);
  sdvem_error_monitor DUT (.sys_clk, .srst, .host_addr, .host_wr, .host_rd, .host_wdata,
    .host_rdata, .smpte_mode, .locked, .manual_mode(manual), .video_processing_bypass_n(bypass_n),
    .field_start, .std_change, .pid_std_mismatch(evt[6]), .anc_checksum_error(evt[2]),
    .active_start_code_error(evt[1]), .active_end_code_error(evt[0]), .fmt_525,
    .fmt_625(1'b0), .field_id(1'b0), .line_num, .pixel_num,
    .flywheel_active_line(1'b1), .between_sav_eav, .word_valid(1'b1),
    .video_word(10'h3ff), .edh_rx_valid(edh_v), .edh_rx_ok(edh_ok), .edh_rx_ap_crc(crc_ap),
    .edh_rx_ff_crc(crc_ff), .data_error_n);
  // Compares one value and counts it.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Reads a register and compares it.
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    u_host.rd(a, d);
    chk(d, exp);
  endtask
  // One-cycle event pulse, then lets the flag updates land.
  task automatic pulse(input logic [6:0] v);
    @(posedge sys_clk);
    evt <= v;
    @(posedge sys_clk);
    evt <= 7'h00;
    #1;
  endtask
  // Presents one received EDH packet.
  task automatic edh(input logic ok, input logic [15:0] ap, input logic [15:0] ff);
    @(posedge sys_clk);
    edh_v <= 1'b1;
    edh_ok <= ok;
    crc_ap <= ap;
    crc_ff <= ff;
    @(posedge sys_clk);
    edh_v <= 1'b0;
  endtask
  // Feeds one word at a given position, then starts a field to bank the CRCs.
  task automatic feed(input logic [10:0] ln, input logic [12:0] px, input logic act);
    @(posedge sys_clk);
    line_num <= ln;
    pixel_num <= px;
    between_sav_eav <= act;
    @(posedge sys_clk);
    line_num <= 11'h000;
    pixel_num <= 13'h0000;
    between_sav_eav <= 1'b0;
    field_start <= 1'b1;
    @(posedge sys_clk);
    field_start <= 1'b0;
  endtask
  // Prints the verdict and ends the run.
  task automatic results();
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Cuts a hung run short.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      results();
    end
  end
  // Main sequence: reset values, each flag, clears, disables, ranges.
  initial begin
    repeat (4) @(posedge sys_clk);
    fork
      begin
        @(posedge sys_clk);
        srst <= 1'b0;
      end
      rdchk(8'h01, 16'h0000);
    join
    rdchk(8'h25, 16'h0000);
    rdchk(8'h15, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      pulse(evs[i]);
      chk({15'h0000, data_error_n}, 16'h0000);
      rdchk(8'h01, {9'h000, evs[i]});
      rdchk(8'h01, 16'h0000);
    end
    edh(1'b0, 16'h0001, 16'h0001);
    rdchk(8'h01, 16'h0000);
    for (int i = 1; i < 4; i++) begin
      edh(1'b1, {15'h0000, i[0]}, {15'h0000, i[1]});
      rdchk(8'h01, {10'h000, i[1:0], 4'h0});
    end
    u_host.wr(8'h25, 16'hff04);
    rdchk(8'h25, 16'h0004);
    pulse(7'h07);
    rdchk(8'h01, 16'h0003);
    u_host.wr(8'h25, 16'h0000);
    smpte_mode <= 1'b0;
    pulse(7'h47);
    rdchk(8'h01, 16'h0000);
    smpte_mode <= 1'b1;
    pulse(7'h04);
    @(posedge sys_clk);
    field_start <= 1'b1;
    evt <= 7'h01;
    @(posedge sys_clk);
    field_start <= 1'b0;
    evt <= 7'h00;
    rdchk(8'h01, 16'h0001);
    pulse(7'h02);
    @(posedge sys_clk);
    std_change <= 1'b1;
    @(posedge sys_clk);
    std_change <= 1'b0;
    rdchk(8'h01, 16'h0000);
    manual <= 1'b1;
    bypass_n <= 1'b0;
    pulse(7'h04);
    repeat (3) @(posedge sys_clk);
    rdchk(8'h01, 16'h0000);
    manual <= 1'b0;
    bypass_n <= 1'b1;
    pulse(7'h02);
    locked <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rdchk(8'h01, 16'h0008);
    rdchk(8'h01, 16'h0008);
    locked <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rdchk(8'h01, 16'h0000);
    u_host.wr(8'h15, 16'hffff);
    rdchk(8'h15, 16'h07ff);
    u_host.wr(8'h24, 16'hffff);
    rdchk(8'h24, 16'h1fff);
    u_host.wr(8'h01, 16'hffff);
    rdchk(8'h01, 16'h0000);
    rdchk(8'h30, 16'h0000);
    fmt_525 <= 1'b0;
    feed(11'h000, 13'h0000, 1'b1);
    edh(1'b1, 16'h4ba3, 16'h0000);
    rdchk(8'h01, 16'h0020);
    for (int k = 0; k < 16; k++) begin
      u_host.wr(8'h15 + k[7:0], 16'h0001);
    end
    feed(11'h001, 13'h0001, 1'b0);
    edh(1'b1, 16'h4ba3, 16'h4ba3);
    rdchk(8'h01, 16'h0000);
    results();
  end
endmodule
`default_nettype wire
